// ==== blf_pkg.sv ====
// Shared constants and types for the bridge lock forwarding block.
package blf_pkg;

	// Address and identity widths.
	localparam int unsigned BLF_ADDR_W   = 32;
	localparam int unsigned BLF_MID_W    = 2;
	// A locked resource is a naturally aligned block of this many bytes.
	localparam int unsigned BLF_LOCK_BYTES = 16;
	localparam int unsigned BLF_GRAN_LSB   = $clog2(BLF_LOCK_BYTES);
	localparam int unsigned BLF_REGION_W   = BLF_ADDR_W - BLF_GRAN_LSB;

	// Routing field of the terminal routing word, bits 19 to 16.
	localparam int unsigned BLF_ROUTE_LSB = 16;
	localparam int unsigned BLF_ROUTE_MSB = 19;
	localparam int unsigned BLF_ROUTE_W   = BLF_ROUTE_MSB - BLF_ROUTE_LSB + 1;
	// Routing code that selects the lock signal on terminal four.
	localparam logic [3:0]  BLF_ROUTE_LOCK = 4'h5;

	// Master identity reserved for the cache write-back agent.
	localparam logic [1:0]  BLF_CACHE_ID = 2'h3;

	// Reset values.
	localparam logic [BLF_REGION_W-1:0] BLF_REGION_RST = '0;
	localparam logic [1:0]              BLF_OWNER_RST  = 2'h0;

	// Requester states.
	typedef enum logic [1:0] {
		BLF_RQ_IDLE = 2'b00,
		BLF_RQ_WAIT = 2'b01,
		BLF_RQ_DONE = 2'b10
	} blf_rq_state_t;

	// Locked 16-byte block number of a byte address.
	function automatic logic [BLF_REGION_W-1:0] blf_region(
		input logic [BLF_ADDR_W-1:0] addr);
		blf_region = addr[BLF_ADDR_W-1:BLF_GRAN_LSB];
	endfunction : blf_region

endpackage : blf_pkg

// ==== blf_link_if.sv ====
// Link between the upstream party and the lock forwarding bridge.
`timescale 1ns/1ps
`default_nettype none
interface blf_link_if
	import blf_pkg::*;
(
	input wire logic i_core_clk
);
	// Request, one-cycle pulse from the upstream party.
	logic                  req_valid;
	logic [BLF_ADDR_W-1:0] req_addr;
	logic                  req_write;
	logic                  req_excl;
	logic                  req_upstream;
	logic [BLF_MID_W-1:0]  req_master;
	// Lock level and bus idle from the upstream party.
	logic                  lock_asserted;
	logic                  bus_idle;
	// Answer, one-cycle pulses from the bridge.
	logic                  ack;
	logic                  retry;
	logic                  posted;
	// Bridge lock state levels.
	logic                  lock_held;
	logic [BLF_MID_W-1:0]  lock_owner;

	modport dev (
		input  req_valid, req_addr, req_write, req_excl, req_upstream,
		input  req_master, lock_asserted, bus_idle,
		output ack, retry, posted, lock_held, lock_owner
	);
	modport up (
		output req_valid, req_addr, req_write, req_excl, req_upstream,
		output req_master, lock_asserted, bus_idle,
		input  ack, retry, posted, lock_held, lock_owner
	);
endinterface : blf_link_if
`default_nettype wire

// ==== blf_bridge.sv ====
// Bridge end: lock tracking, region compare and posting control.
//
// Overview of operation
// - Lock drives terminal four only when routed.
// - Only downstream locks are honoured and forwarded.
// - Non-exclusive accesses outside locked block complete.
// - Bus grant alone never confers lock ownership.
// - Lock region is an aligned 16-byte block.
// - Full-lock arbiter grants only the lock owner and the cache.
// - Full-lock arbiter still grants the cache.
// - Full bridge lock behaviour on the card side.
// - Write posting disabled while a lock is held.
// - Lock carried to card on separate lock signal.
// - Card target never blocks all access to itself.
`timescale 1ns/1ps
`default_nettype none
module blf_bridge
	import blf_pkg::*;
(
	// Clock and reset.
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	// Link to the upstream party.
	blf_link_if.dev                     link,
	// Routing field of the terminal routing word.
	input  wire logic [BLF_ROUTE_W-1:0] i_route_sel,
	// Terminal four, drive side.
	output logic                        o_multifunction_pin_four_o,
	output logic                        o_multifunction_pin_four_oe,
	// Card-side lock, active low.
	output logic                        o_card_side_lock_n,
	// Status levels and pulses.
	output logic                        o_posting_en,
	output logic                        o_up_lock_ignored
);

	// All state of the bridge.
	typedef struct packed {
		logic                    lock_on;
		logic                    lock_seen;
		logic [BLF_MID_W-1:0]    owner;
		logic [BLF_REGION_W-1:0] region;
		logic                    ack;
		logic                    retry;
		logic                    posted;
		logic                    post_en;
		logic                    pin_o;
		logic                    pin_oe;
		logic                    card_lock_n;
		logic                    up_ign;
	} blf_brg_st_t;

	blf_brg_st_t st_q;
	blf_brg_st_t st_d;

	// Decode of the current request.
	logic region_hit;
	logic from_owner;
	logic excl_down;
	logic routed;

	// Request classification against the held lock.
	always_comb begin
		// Compare whole 16-byte blocks, not bytes.
		region_hit = st_q.lock_on
			&& (blf_region(link.req_addr) == st_q.region);
		// Ownership comes from the lock handshake, never from the grant.
		from_owner = st_q.lock_on && (link.req_master == st_q.owner);
		// Exclusive requests travelling toward the card only.
		excl_down = link.req_excl && !link.req_upstream;
		routed = (i_route_sel == BLF_ROUTE_LOCK);
	end

	// Next-state logic.
	always_comb begin
		st_d        = st_q;
		st_d.ack    = 1'b0;
		st_d.retry  = 1'b0;
		st_d.posted = 1'b0;
		st_d.up_ign = 1'b0;

		if (link.req_valid) begin
			if (region_hit && !from_owner) begin
				// Locked block belongs to another master: retry it.
				st_d.retry = 1'b1;
			end else begin
				// Accesses outside the locked block go through normally.
				st_d.ack = 1'b1;
				// Writes post only while no lock is active or starting.
				st_d.posted = link.req_write && st_q.post_en
					&& !(excl_down && !st_q.lock_on);
				if (excl_down && !st_q.lock_on) begin
					// A new downstream lock captures owner and block.
					st_d.lock_on   = 1'b1;
					st_d.lock_seen = 1'b0;
					st_d.owner     = link.req_master;
					st_d.region    = blf_region(link.req_addr);
				end
			end
			if (link.req_excl && link.req_upstream) begin
				// A card-originated lock is not carried back onto PCI.
				st_d.up_ign = 1'b1;
			end
		end

		// Note that the owner has asserted the lock line.
		if (st_q.lock_on && link.lock_asserted) begin
			st_d.lock_seen = 1'b1;
		end

		// Release once the owner has dropped lock and the bus is idle.
		if (st_q.lock_on && st_q.lock_seen && !link.lock_asserted
			&& link.bus_idle && !link.req_valid) begin
			st_d.lock_on   = 1'b0;
			st_d.lock_seen = 1'b0;
		end

		// Posting follows the lock state; re-enabled at release.
		st_d.post_en = !st_d.lock_on;

		// Card-side lock mirrors the held downstream lock.
		st_d.card_lock_n = !(st_d.lock_on && (link.lock_asserted
			|| !st_q.lock_seen));

		// Terminal four shows the lock level only when routed there.
		st_d.pin_oe = routed;
		st_d.pin_o  = routed ? !link.lock_asserted : 1'b0;
	end

	// State register with synchronous reset.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_q.lock_on     <= 1'b0;
			st_q.lock_seen   <= 1'b0;
			st_q.owner       <= BLF_OWNER_RST;
			st_q.region      <= BLF_REGION_RST;
			st_q.ack         <= 1'b0;
			st_q.retry       <= 1'b0;
			st_q.posted      <= 1'b0;
			st_q.post_en     <= 1'b1;
			st_q.pin_o       <= 1'b0;
			st_q.pin_oe      <= 1'b0;
			st_q.card_lock_n <= 1'b1;
			st_q.up_ign      <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// Link answers come straight from the state register.
	assign link.ack        = st_q.ack;
	assign link.retry      = st_q.retry;
	assign link.posted     = st_q.posted;
	assign link.lock_held  = st_q.lock_on;
	assign link.lock_owner = st_q.owner;

	// User-side outputs, all registered.
	assign o_multifunction_pin_four_o  = st_q.pin_o;
	assign o_multifunction_pin_four_oe = st_q.pin_oe;
	assign o_card_side_lock_n          = st_q.card_lock_n;
	assign o_posting_en                = st_q.post_en;
	assign o_up_lock_ignored           = st_q.up_ign;

endmodule : blf_bridge
`default_nettype wire

// ==== blf_upstream.sv ====
// Upstream end: arbiter with optional full lock and a single requester.
`timescale 1ns/1ps
`default_nettype none
module blf_upstream
	import blf_pkg::*;
(
	// Clock and reset.
	input  wire logic                  i_core_clk,
	input  wire logic                  i_rst_n,
	// Link to the bridge.
	blf_link_if.up                     link,
	// Arbiter mode.
	input  wire logic                  i_full_lock,
	// User request.
	input  wire logic                  i_req,
	input  wire logic [BLF_MID_W-1:0]  i_master,
	input  wire logic [BLF_ADDR_W-1:0] i_addr,
	input  wire logic                  i_write,
	input  wire logic                  i_excl,
	input  wire logic                  i_upstream,
	// Owner ends its locked sequence.
	input  wire logic                  i_unlock,
	// User answer.
	output logic                       o_busy,
	output logic                       o_done,
	output logic                       o_retry,
	output logic                       o_refused,
	output logic                       o_lock_asserted
);

	// All state of the upstream end.
	typedef struct packed {
		blf_rq_state_t         state;
		logic                  vld;
		logic [BLF_ADDR_W-1:0] addr;
		logic                  write;
		logic                  excl;
		logic                  upstr;
		logic [BLF_MID_W-1:0]  mid;
		logic                  lock;
		logic [BLF_MID_W-1:0]  lock_mid;
		logic                  done;
		logic                  retry;
		logic                  refused;
	} blf_up_st_t;

	blf_up_st_t st_q;
	blf_up_st_t st_d;
	logic       grant;

	// Full lock admits only the owner and the cache.
	always_comb begin
		grant = !(i_full_lock && st_q.lock)
			|| (i_master == st_q.lock_mid)
			|| (i_master == BLF_CACHE_ID);
	end

	// Next-state logic.
	always_comb begin
		st_d         = st_q;
		st_d.vld     = 1'b0;
		st_d.done    = 1'b0;
		st_d.retry   = 1'b0;
		st_d.refused = 1'b0;
		unique case (st_q.state)
			BLF_RQ_IDLE: begin
				if (i_req && grant) begin
					// Any granted master may use the bus during a lock.
					st_d.vld   = 1'b1;
					st_d.addr  = i_addr;
					st_d.write = i_write;
					st_d.excl  = i_excl;
					st_d.upstr = i_upstream;
					st_d.mid   = i_master;
					st_d.state = BLF_RQ_WAIT;
				end else if (i_req) begin
					st_d.refused = 1'b1;
				end
			end
			BLF_RQ_WAIT: begin
				if (link.ack || link.retry) begin
					st_d.done  = link.ack;
					// A retry frees the bus so others keep progressing.
					st_d.retry = link.retry;
					if (link.ack && st_q.excl && !st_q.upstr
						&& !st_q.lock) begin
						// Lock handshake completes with the first access.
						st_d.lock     = 1'b1;
						st_d.lock_mid = st_q.mid;
					end
					st_d.state = BLF_RQ_DONE;
				end
			end
			BLF_RQ_DONE: begin
				st_d.state = BLF_RQ_IDLE;
			end
			default: begin
				st_d.state = BLF_RQ_IDLE;
			end
		endcase
		if (i_unlock && st_q.lock && st_q.state == BLF_RQ_IDLE) begin
			st_d.lock = 1'b0;
		end
	end

	// State register with synchronous reset.
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			st_q <= '{state: BLF_RQ_IDLE, mid: BLF_OWNER_RST,
				lock_mid: BLF_OWNER_RST, default: '0};
		end else begin
			st_q <= st_d;
		end
	end

	// Link drive.
	assign link.req_valid     = st_q.vld;
	assign link.req_addr      = st_q.addr;
	assign link.req_write     = st_q.write;
	assign link.req_excl      = st_q.excl;
	assign link.req_upstream  = st_q.upstr;
	assign link.req_master    = st_q.mid;
	assign link.lock_asserted = st_q.lock;
	assign link.bus_idle      = (st_q.state == BLF_RQ_IDLE);

	// User outputs, all registered except o_busy, decoded from the state.
	assign o_busy          = (st_q.state != BLF_RQ_IDLE);
	assign o_done          = st_q.done;
	assign o_retry         = st_q.retry;
	assign o_refused       = st_q.refused;
	assign o_lock_asserted = st_q.lock;

endmodule : blf_upstream
`default_nettype wire

// ==== blf_props.sv ====
// Checker of the link between the upstream end and the bridge end.
`timescale 1ns/1ps
`default_nettype none
module blf_props
	import blf_pkg::*;
(
	// Clock and reset.
	input wire logic                  i_core_clk,
	input wire logic                  i_rst_n,
	// Link signals.
	input wire logic                  req_valid,
	input wire logic [BLF_ADDR_W-1:0] req_addr,
	input wire logic                  req_write,
	input wire logic                  req_excl,
	input wire logic                  req_upstream,
	input wire logic [BLF_MID_W-1:0]  req_master,
	input wire logic                  lock_asserted,
	input wire logic                  bus_idle,
	input wire logic                  ack,
	input wire logic                  retry,
	input wire logic                  posted,
	input wire logic                  lock_held,
	input wire logic [BLF_MID_W-1:0]  lock_owner
);
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	// Each request is answered once, the cycle after it is taken.
	property p_answer; req_valid |=> (ack ^ retry); endproperty
	a_answer: assert property (p_answer) else $error("no answer");
	property p_cause; (ack || retry) |-> $past(req_valid); endproperty
	a_cause: assert property (p_cause) else $error("stray answer");
	// Posting only for plain writes taken while no lock is held.
	property p_post;
		posted |-> ack && $past(req_write)
			&& !($past(req_excl) && !$past(req_upstream))
			&& !$past(lock_held);
	endproperty
	a_post: assert property (p_post) else $error("bad posting");
	property p_upstream;
		req_valid && req_upstream && !lock_held |=> !lock_held;
	endproperty
	a_upstream: assert property (p_upstream) else $error("up lock");
	property p_take;
		req_valid && req_excl && !req_upstream && !lock_held
			|=> lock_held && lock_owner == $past(req_master);
	endproperty
	a_take: assert property (p_take) else $error("lock not taken");
	property p_retry;
		retry |-> $past(lock_held) && $past(req_master) != $past(lock_owner);
	endproperty
	a_retry: assert property (p_retry) else $error("bad retry");
	property p_owner; lock_held && $past(lock_held) |-> $stable(lock_owner);
	endproperty
	a_owner: assert property (p_owner) else $error("owner moved");
	property p_release;
		lock_held && !lock_asserted && bus_idle && !req_valid |=> !lock_held;
	endproperty
	a_release: assert property (p_release) else $error("no release");

	// Main scenarios.
	c_take: cover property (req_valid && req_excl ##1 lock_held);
	c_retry: cover property (retry);
	c_release: cover property (lock_held ##1 !lock_held);
endmodule : blf_props
`default_nettype wire

// ==== tb_bridge_lock_forwarding.sv ====
// Self-checking testbench of both lock forwarding ends.
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_lock_forwarding
	import blf_pkg::*;
;
	logic        clk = 0, rst_n = 0, full = 0, req = 0, wr = 0, ex = 0;
	logic        up = 0, unl = 0, pin_o, pin_oe, card_n, post_en, ign;
	logic        busy, done, rtry, refd, lk_as;
	logic [1:0]  mst = 0;
	logic [31:0] adr = 0;
	logic [3:0]  route = 0;
	logic [27:0] lk_blk;
	logic [1:0]  lk_m;
	bit          lk;
	int          bad_count = 0, checks = 0, r;
	int          ign_n = 0;

	// Clock and the two ends joined by the link.
	always #5 clk = ~clk;
	blf_link_if link (.i_core_clk(clk));
	blf_bridge blf_bridge_inst (.i_core_clk(clk), .i_rst_n(rst_n),
		.link(link), .i_route_sel(route),
		.o_multifunction_pin_four_o(pin_o),
		.o_multifunction_pin_four_oe(pin_oe),
		.o_card_side_lock_n(card_n), .o_posting_en(post_en),
		.o_up_lock_ignored(ign));
	blf_upstream blf_upstream_inst (.i_core_clk(clk), .i_rst_n(rst_n),
		.link(link), .i_full_lock(full), .i_req(req), .i_master(mst),
		.i_addr(adr), .i_write(wr), .i_excl(ex), .i_upstream(up),
		.i_unlock(unl), .o_busy(busy), .o_done(done), .o_retry(rtry),
		.o_refused(refd), .o_lock_asserted(lk_as));
	blf_props blf_props_inst (.i_core_clk(clk), .i_rst_n(rst_n),
		.req_valid(link.req_valid), .req_addr(link.req_addr),
		.req_write(link.req_write), .req_excl(link.req_excl),
		.req_upstream(link.req_upstream), .req_master(link.req_master),
		.lock_asserted(link.lock_asserted), .bus_idle(link.bus_idle),
		.ack(link.ack), .retry(link.retry), .posted(link.posted),
		.lock_held(link.lock_held), .lock_owner(link.lock_owner));

	// Counts the pulses that flag an ignored card-side lock.
	always @(posedge clk) if (ign === 1'b1) ign_n++;

	// Counts a comparison and reports a miss.
	task automatic chk(input bit ok, input string msg);
		checks++;
		if (!ok) begin
			bad_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask : chk

	// Outcome 0 done, 1 retry, 2 refused, from the bench's lock model.
	function automatic int want(logic [31:0] a, logic [1:0] m);
		if (lk && full && m != lk_m && m != BLF_CACHE_ID) return 2;
		if (lk && m != lk_m && a[31:4] == lk_blk) return 1;
		return 0;
	endfunction : want

	// One access through the upstream user port, checked against want.
	task automatic acc(input logic [1:0] m, input logic [31:0] a,
		input logic w, input logic x, input logic u);
		int e;
		e = want(a, m);
		@(posedge clk);
		{req, mst, adr, wr, ex, up} <= {1'b1, m, a, w, x, u};
		@(posedge clk);
		req <= 1'b0;
		r = 3;
		repeat (12) if (r == 3) begin
			#1;
			if (done === 1'b1) r = 0;
			else if (rtry === 1'b1) r = 1;
			else if (refd === 1'b1) r = 2;
			else @(posedge clk);
		end
		chk(r == e && busy === (r != 2), "access outcome");
		if (x && !u && e == 0 && !lk) {lk, lk_m, lk_blk} = {1'b1, m, a[31:4]};
	endtask : acc

	// Owner ends its locked sequence; lock state must clear.
	task automatic release_lock();
		@(posedge clk);
		unl <= 1'b1;
		repeat (6) @(posedge clk);
		unl <= 1'b0;
		lk = 0;
		#1;
		chk(post_en === 1'b1 && card_n === 1'b1 && pin_o === 1'b1
			&& lk_as === 1'b0, "lock kept");
	endtask : release_lock

	// Prints the counts and the verdict.
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_sim

	// Watchdog.
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		end_sim();
	end

	// Main sequence.
	initial begin
		logic [31:0] a;
		void'($urandom(32'h6B3744BD));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 16; c++) begin
			@(posedge clk);
			route <= c[3:0];
			repeat (2) @(posedge clk);
			#1;
			chk(pin_oe === (c[3:0] == BLF_ROUTE_LOCK), "pin enable");
		end
		// Route the lock to terminal four for the rest of the run.
		@(posedge clk);
		route <= BLF_ROUTE_LOCK;
		a = $urandom;
		acc(2'h0, a, 1'b1, 1'b0, 1'b0);
		chk(post_en === 1'b1, "posting off");
		acc(2'h1, a, 1'b1, 1'b1, 1'b1);
		chk(card_n === 1'b1 && post_en === 1'b1 && ign_n == 1, "up lock");
		release_lock();
		for (int f = 0; f < 2; f++) begin
			@(posedge clk);
			full <= f[0];
			acc(2'h1, a, 1'b1, 1'b1, 1'b0);
			chk(post_en === 1'b0 && card_n === 1'b0, "lock state");
			chk(lk_as === 1'b1 && busy === 1'b1, "lock line");
			// The pin follows the lock line one cycle later.
			@(posedge clk);
			#1;
			chk(pin_o === 1'b0 && pin_oe === 1'b1, "pin level");
			acc(2'h2, {a[31:4], ~a[3:0]}, 1'b1, 1'b0, 1'b0);
			acc(2'h3, a + 32'h10, 1'b1, 1'b0, 1'b0);
			acc(2'h1, a ^ 32'hF, 1'b1, 1'b0, 1'b0);
			repeat (8) acc(2'($urandom_range(2)), ($urandom & 1) ? {a[31:4],
				4'($urandom)} : $urandom, 1'($urandom), 1'b0, 1'b0);
			release_lock();
			a = $urandom;
		end
		end_sim();
	end
endmodule : tb_bridge_lock_forwarding
`default_nettype wire
